/* logic/nic_pkg.sv */
package nic_pkg;
   localparam int NSRC = 14;
   localparam int EXT_FIRST = 2;
   localparam int EXT_LINES = 4;
   localparam logic [7:0] OFS_ISPR0 = 8'h00;
   localparam logic [7:0] OFS_ISPR3 = 8'h0C;
   localparam logic [7:0] OFS_EN = 8'h10;
   localparam logic [7:0] OFS_PINEN = 8'h14;
   localparam logic [7:0] OFS_LVL = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   localparam logic [7:0] OFS_CTRL = 8'h20;
   localparam logic [7:0] ISPR_RST = 8'hFF;
   localparam logic [7:0] ISPR3_RO = 8'hF0;
   localparam logic [13:0] EN_RST = 14'h0000;
   localparam logic CTRL_RISE_RST = 1'b1;
   localparam logic [1:0] LVL0 = 2'b10;
   localparam logic [1:0] LVL1 = 2'b01;
   localparam logic [1:0] LVL2 = 2'b00;
   localparam logic [1:0] LVL3 = 2'b11;
   localparam int LVL_HI_POS = 5;
   localparam int LVL_LO_POS = 3;
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP = 16'hFFFC;
   localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
   localparam logic [13:0] HALT_CAP_DEF = 14'h21BF;
   localparam logic [13:0] EXT_MASK = 14'h003C;
   localparam logic [3:0] TLI_IDX = 4'h0;

   typedef enum logic [3:0] {
      ST_RST = 4'b0001,
      ST_IDLE = 4'b0010,
      ST_STACK = 4'b0100,
      ST_VECT = 4'b1000
   } nic_state_e;

   typedef struct packed {
      logic boundary;
      logic push_done;
      logic trap;
      logic enable_irq_instr;
      logic sim;
      logic wait_for_irq_instr;
      logic halt;
      logic return_from_irq;
      logic [1:0] return_from_irq_lvl;
   } nic_core_cmd_s;

   typedef struct packed {
      logic push;
      logic vec_load;
      logic [15:0] vec;
      logic [1:0] level;
      logic wake;
   } nic_core_rsp_s;
endpackage

/* logic/nic_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// [RQ1] entry starts only at an instruction boundary reported by the core
// [RQ2] context push is requested and completed before the vector loads
// [RQ3] on entry the level takes the serviced vector's stored priority
// [RQ4] vector address is presented with the load pulse after stacking
// [RQ5] return restores the level popped by the core
// [RQ6] level bits sit at 5 and 3: 10,01,00,11 for levels 0..3
// [RQ7] highest software priority pending request wins
// [RQ8] ties go to the lowest source index, the highest hardware priority
// [RQ9] pin requests stay latched until they win; peripheral ones drop with flag or enable
// [RQ10] reset, trap and top pin rank above all and ignore level 3
// [RQ11] non-maskable entries skip the level check and set level 3
// [RQ12] reset and halt-capable sources can end halt; trap cannot
// [RQ13] trap is taken like the top pin; top pin may preempt a trap routine
// [RQ14] reset vector loads first after reset at level 3
// [RQ15] maskable needs enable and priority strictly above current level
// [RQ16] top pin raises its request on the selected edge
// [RQ17] software must not trap inside the top pin routine
// [RQ18] external edge requests latch and clear on routine entry
// [RQ19] enabled pins of one external line are ORed
// [RQ20] peripheral request needs both flag and enable
// [RQ21] peripheral clear sequence drops a waiting request
// [RQ22] any source wakes from wait; only halt-capable ones from halt
// [RQ23] first service after halt wake must be halt-capable
// [RQ24] priority fields reset to ones; writing level 0 keeps old field
// [RQ25] enable instruction loads 10, disable instruction loads 11
// [RQ26] arbitration is combinational from latches and level
// [RQ27] all vectors at level 3 gives concurrent mode, lower allows nesting
module nic_ctrl #(
   parameter int PINS_PER_LINE = 2,
   parameter logic [13:0] HALT_CAP = nic_pkg::HALT_CAP_DEF
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tli_pin,
   input wire logic [nic_pkg::EXT_LINES*PINS_PER_LINE-1:0] ext_pin,
   input wire logic [13:0] periph_flag,
   input wire logic [13:0] periph_clr,
   input wire nic_pkg::nic_core_cmd_s core_cmd,
   output nic_pkg::nic_core_rsp_s core_rsp
);
   localparam int NPIN = nic_pkg::EXT_LINES * PINS_PER_LINE;

   function automatic logic [1:0] lvl_num(input logic [1:0] p);
      case (p)
         nic_pkg::LVL0: lvl_num = 2'h0;
         nic_pkg::LVL1: lvl_num = 2'h1;
         nic_pkg::LVL2: lvl_num = 2'h2;
         default: lvl_num = 2'h3;
      endcase
   endfunction

   function automatic logic [1:0] fld(input logic [3:0][7:0] r, input logic [3:0] i);
      fld = r[i[3:2]][{i[1:0], 1'b0} +: 2];
   endfunction

   // level-0 pattern is not storable: field keeps its old value
   function automatic logic [7:0] ispr_wr(input logic [7:0] o, input logic [7:0] n);
      logic [7:0] r;
      r = n;
      for (int f = 0; f < 4; f++) begin
         if (n[2*f +: 2] == nic_pkg::LVL0) begin
            r[2*f +: 2] = o[2*f +: 2];
         end
      end
      ispr_wr = r;
   endfunction

   nic_pkg::nic_state_e st_ff, nxt_st;
   logic [3:0][7:0] ispr_ff;
   logic [13:0] en_ff;
   logic [NPIN-1:0] pin_en_ff;
   logic tli_rise_ff;
   logic [1:0] level_ff, nxt_level;
   logic [13:0] pend_ff, nxt_pend;
   logic trap_ff;
   logic wait_ff, halt_ff, hfirst_ff, wake_ff;
   logic [3:0] sel_idx_ff;
   logic sel_trap_ff, sel_rst_ff;
   logic push_ff, vec_load_ff;
   logic [15:0] vec_ff;
   logic tli_s1_ff, tli_s2_ff, tli_d_ff;
   logic [NPIN-1:0] ext_s1_ff, ext_s2_ff;
   logic [nic_pkg::EXT_LINES-1:0] line_d_ff;
   logic [13:0] pq_d_ff;
   logic pready_ff, pslverr_ff;
   logic [31:0] prdata_ff;

   // apb decode
   wire acc = psel & penable;
   wire setup_acc = acc & ~pready_ff;
   wire wr_fire = acc & pready_ff & pwrite;
   wire hit_isp = (paddr[7:4] == 4'h0) & (paddr[1:0] == 2'b00);
   wire hit_en = paddr == nic_pkg::OFS_EN;
   wire hit_pin = paddr == nic_pkg::OFS_PINEN;
   wire hit_lvl = paddr == nic_pkg::OFS_LVL;
   wire hit_stat = paddr == nic_pkg::OFS_STAT;
   wire hit_ctrl = paddr == nic_pkg::OFS_CTRL;
   wire hit_any = hit_isp | hit_en | hit_pin | hit_lvl | hit_stat | hit_ctrl;
   wire [1:0] isp_sel = paddr[3:2];
   wire [31:0] lvl_word = {24'h0, 2'b00, level_ff[1], 1'b0, level_ff[0], 3'b000}; // RQ6
   wire [31:0] stat_word = {10'h0, st_ff, wait_ff, halt_ff, hfirst_ff, trap_ff, pend_ff};
   wire [31:0] rd_mux = hit_isp ? {24'h0, ispr_ff[isp_sel]} :
                        hit_en ? {18'h0, en_ff} :
                        hit_pin ? 32'(pin_en_ff) :
                        hit_lvl ? lvl_word :
                        hit_stat ? stat_word :
                        hit_ctrl ? {31'h0, tli_rise_ff} : 32'h0;

   // source conditioning
   wire tli_edge = tli_rise_ff ? (tli_s2_ff & ~tli_d_ff) : (~tli_s2_ff & tli_d_ff); // RQ16
   wire [nic_pkg::EXT_LINES-1:0] line_now;
   genvar g;
   for (g = 0; g < nic_pkg::EXT_LINES; g++) begin : g_line
      assign line_now[g] = |(ext_s2_ff[g*PINS_PER_LINE +: PINS_PER_LINE]
                             & pin_en_ff[g*PINS_PER_LINE +: PINS_PER_LINE]); // RQ19
   end
   wire [13:0] pq = periph_flag & en_ff; // RQ20

   // arbitration over latched requests
   logic win_ok;
   logic [3:0] win_idx;
   logic [13:0] elig;
   always_comb begin
      logic [2:0] best;
      logic [2:0] sc;
      best = 3'h0;
      sc = 3'h0;
      win_ok = 1'b0;
      win_idx = 4'h0;
      elig = 14'h0;
      for (int i = 0; i < nic_pkg::NSRC; i++) begin
         if (i == 0) begin
            elig[i] = pend_ff[i] & en_ff[i]; // RQ10
            sc = 3'h4;
         end else begin
            elig[i] = pend_ff[i] & en_ff[i]
                      & (lvl_num(fld(ispr_ff, 4'(i))) > lvl_num(level_ff)); // RQ15 RQ27
            sc = {1'b0, lvl_num(fld(ispr_ff, 4'(i)))};
         end
         if (hfirst_ff & ~HALT_CAP[i]) begin
            elig[i] = 1'b0; // RQ23
         end
         // strict compare keeps the lower index on ties
         if (elig[i] & (~win_ok | (sc > best))) begin // RQ7 RQ8
            win_ok = 1'b1;
            win_idx = 4'(i);
            best = sc;
         end
      end
   end // RQ26

   wire asleep = wait_ff | halt_ff;
   wire go = (st_ff == nic_pkg::ST_IDLE) & core_cmd.boundary & ~asleep
             & (trap_ff | win_ok); // RQ1 RQ9
   wire push_end = (st_ff == nic_pkg::ST_STACK) & core_cmd.push_done;
   wire load_now = push_end | (st_ff == nic_pkg::ST_RST);
   wire vect_now = (st_ff == nic_pkg::ST_VECT) & ~sel_trap_ff & ~sel_rst_ff;
   wire [13:0] wake_src = pend_ff & en_ff;
   wire wake_now = (wait_ff & (|wake_src)) | (halt_ff & (|(wake_src & HALT_CAP))); // RQ22
   wire [1:0] ent_level = (sel_trap_ff | (sel_idx_ff == nic_pkg::TLI_IDX))
                          ? nic_pkg::LVL3 : fld(ispr_ff, sel_idx_ff); // RQ3 RQ11
   wire [15:0] ent_vec = (st_ff == nic_pkg::ST_RST) ? nic_pkg::VEC_RESET :
                         sel_trap_ff ? nic_pkg::VEC_TRAP :
                         nic_pkg::VEC_SRC0 - {11'h000, sel_idx_ff, 1'b0}; // RQ4 RQ14

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         nic_pkg::ST_RST: nxt_st = nic_pkg::ST_VECT; // RQ14
         nic_pkg::ST_IDLE: if (go) nxt_st = nic_pkg::ST_STACK;
         nic_pkg::ST_STACK: if (core_cmd.push_done) nxt_st = nic_pkg::ST_VECT; // RQ2
         nic_pkg::ST_VECT: nxt_st = nic_pkg::ST_IDLE;
         default: nxt_st = nic_pkg::ST_IDLE;
      endcase
   end

   always_comb begin
      if (load_now) begin
         nxt_level = (st_ff == nic_pkg::ST_RST) ? nic_pkg::LVL3 : ent_level; // RQ3
      end else if (core_cmd.return_from_irq) begin
         nxt_level = core_cmd.return_from_irq_lvl; // RQ5
      end else if (core_cmd.enable_irq_instr | core_cmd.wait_for_irq_instr | core_cmd.halt) begin
         nxt_level = nic_pkg::LVL0; // RQ25
      end else if (core_cmd.sim) begin
         nxt_level = nic_pkg::LVL3; // RQ25
      end else if (wr_fire & hit_lvl) begin
         nxt_level = {pwdata[nic_pkg::LVL_HI_POS], pwdata[nic_pkg::LVL_LO_POS]};
      end else begin
         nxt_level = level_ff;
      end
   end

   // set always wins over any clear in the same cycle
   always_comb begin
      logic set;
      logic clr;
      set = 1'b0;
      clr = 1'b0;
      nxt_pend = pend_ff;
      for (int i = 0; i < nic_pkg::NSRC; i++) begin
         if (i == 0) begin
            set = tli_edge;
            clr = vect_now & (sel_idx_ff == 4'(i));
         end else if (nic_pkg::EXT_MASK[i]) begin
            set = line_now[i-nic_pkg::EXT_FIRST] & ~line_d_ff[i-nic_pkg::EXT_FIRST];
            clr = vect_now & (sel_idx_ff == 4'(i)); // RQ18
         end else begin
            set = pq[i] & ~pq_d_ff[i];
            clr = periph_clr[i] | ~pq[i]; // RQ21
         end
         nxt_pend[i] = set | (pend_ff[i] & ~clr);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tli_s1_ff <= 1'b0;
         tli_s2_ff <= 1'b0;
         tli_d_ff <= 1'b0;
         ext_s1_ff <= '0;
         ext_s2_ff <= '0;
         line_d_ff <= '0;
         pq_d_ff <= 14'h0000;
      end else begin
         tli_s1_ff <= tli_pin;
         tli_s2_ff <= tli_s1_ff;
         tli_d_ff <= tli_s2_ff;
         ext_s1_ff <= ext_pin;
         ext_s2_ff <= ext_s1_ff;
         line_d_ff <= line_now;
         pq_d_ff <= pq;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= setup_acc;
         pslverr_ff <= setup_acc & ~hit_any;
         prdata_ff <= setup_acc ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ispr_ff <= {4{nic_pkg::ISPR_RST}}; // RQ24
         en_ff <= nic_pkg::EN_RST;
         pin_en_ff <= '0;
         tli_rise_ff <= nic_pkg::CTRL_RISE_RST;
      end else if (wr_fire) begin
         if (hit_isp) begin
            ispr_ff[isp_sel] <= ispr_wr(ispr_ff[isp_sel], pwdata[7:0]) // RQ24
                                | ((isp_sel == 2'h3) ? nic_pkg::ISPR3_RO : 8'h00);
         end else if (hit_en) begin
            en_ff <= pwdata[13:0];
         end else if (hit_pin) begin
            pin_en_ff <= pwdata[NPIN-1:0];
         end else if (hit_ctrl) begin
            tli_rise_ff <= pwdata[0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= nic_pkg::ST_RST;
         level_ff <= nic_pkg::LVL3; // RQ14
         pend_ff <= 14'h0000;
         trap_ff <= 1'b0;
         sel_idx_ff <= 4'h0;
         sel_trap_ff <= 1'b0;
         sel_rst_ff <= 1'b1;
         push_ff <= 1'b0;
         vec_load_ff <= 1'b0;
         vec_ff <= 16'h0000;
      end else begin
         st_ff <= nxt_st;
         level_ff <= nxt_level;
         pend_ff <= nxt_pend;
         trap_ff <= core_cmd.trap | (trap_ff & ~go); // RQ13
         if (go) begin
            sel_idx_ff <= win_idx;
            sel_trap_ff <= trap_ff; // RQ10
            sel_rst_ff <= 1'b0;
         end
         push_ff <= go | (push_ff & ~core_cmd.push_done); // RQ2
         vec_load_ff <= load_now;
         if (load_now) begin
            vec_ff <= ent_vec;
         end
      end
   end

   // halt and wait tracking; reset itself leaves halt through the async clear
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wait_ff <= 1'b0;
         halt_ff <= 1'b0;
         hfirst_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         wait_ff <= (wait_ff & ~wake_now) | core_cmd.wait_for_irq_instr;
         halt_ff <= (halt_ff & ~wake_now) | core_cmd.halt; // RQ12 RQ22
         wake_ff <= wake_now;
         if (halt_ff & wake_now) begin
            hfirst_ff <= 1'b1; // RQ23
         end else if (st_ff == nic_pkg::ST_VECT) begin
            hfirst_ff <= 1'b0;
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign core_rsp = {push_ff, vec_load_ff, vec_ff, level_ff, wake_ff};

   a_push_at_boundary: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ1
      $rose(push_ff) |-> $past(core_cmd.boundary))
      else $error("push started off an instruction boundary");

   a_stack_then_vec: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ2
      push_ff && core_cmd.push_done |=> vec_load_ff && !push_ff)
      else $error("vector not loaded right after stacking");

   a_entry_level: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ3
      push_end && !sel_trap_ff && sel_idx_ff != 4'h0
      |=> level_ff == fld(ispr_ff, sel_idx_ff))
      else $error("entry level differs from stored priority");

   a_nmi_level3: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
      vec_load_ff && (sel_trap_ff || sel_idx_ff == 4'h0 || sel_rst_ff)
      |-> level_ff == nic_pkg::LVL3)
      else $error("non-maskable entry not at level 3");

   a_return_from_irq_restore: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ5
      core_cmd.return_from_irq && !load_now |=> level_ff == $past(core_cmd.return_from_irq_lvl))
      else $error("return did not restore level");

   a_rim_sim: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ25
      !load_now && !core_cmd.return_from_irq && core_cmd.sim && !core_cmd.enable_irq_instr
      && !core_cmd.wait_for_irq_instr && !core_cmd.halt |=> level_ff == nic_pkg::LVL3)
      else $error("disable instruction did not load level 3");

   a_mask_strict: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ15
      go && !trap_ff && win_idx != 4'h0
      |-> lvl_num(fld(ispr_ff, win_idx)) > lvl_num(level_ff) && en_ff[win_idx])
      else $error("maskable taken without enable or priority");

   a_halt_first: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ23
      go && hfirst_ff && !trap_ff |-> HALT_CAP[win_idx])
      else $error("first service after halt is not halt-capable");

   a_ispr_keep: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ24
      wr_fire && hit_isp && pwdata[1:0] == nic_pkg::LVL0
      |=> ispr_ff[$past(isp_sel)][1:0] == $past(ispr_ff[isp_sel][1:0]))
      else $error("level 0 pattern was stored");

   a_reset_vector: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ14
      st_ff == nic_pkg::ST_RST |=> vec_load_ff && vec_ff == nic_pkg::VEC_RESET && !push_ff)
      else $error("reset vector not loaded without stacking");
endmodule

/* tb/nic_core_model.sv */
`timescale 1ns/1ps
module nic_core_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic push,
   input wire logic [3:0] delay,
   output logic boundary,
   output logic push_done
);
   logic [3:0] cnt_ff;
   // boundary drops while stacking, so an entry never starts mid-push
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 4'h0;
         push_done <= 1'b0;
         boundary <= 1'b0;
      end else begin
         push_done <= 1'b0;
         boundary <= !push;
         if (push && !push_done) begin
            cnt_ff <= cnt_ff + 4'h1;
            // a slow stack write is modelled by a larger delay
            if (cnt_ff >= delay) begin
               push_done <= 1'b1;
               cnt_ff <= 4'h0;
            end
         end
      end
   end
endmodule

/* tb/nic_ctrl_tb.sv */
`timescale 1ns/1ps
module nic_ctrl_tb;
   typedef struct packed {
      logic [3:0] src;
      logic [1:0] prio;
      logic [15:0] vec;
   } nic_row_s;
   localparam nic_row_s ROWS [3] = '{'{4'h1, 2'b01, 16'hFFF8}, '{4'h6, 2'b00, 16'hFFEE},
      '{4'hD, 2'b11, 16'hFFE0}};
   localparam int C_TRAP = 5, C_EN = 4, C_DIS = 3, C_WAIT = 2, C_HALT = 1, C_RET = 0;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tli_pin = 1'b0;
   logic [7:0] ext_pin = 8'h00;
   logic [13:0] periph_flag = 14'h0000;
   logic [13:0] periph_clr = 14'h0000;
   logic [5:0] cmdp = 6'h00;
   logic [1:0] return_from_irq_lvl = 2'b11;
   logic [3:0] dly = 4'h0;
   logic bnd;
   logic pdone;
   nic_pkg::nic_core_cmd_s core_cmd;
   nic_pkg::nic_core_rsp_s core_rsp;
   logic [7:0] prio_sh [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [13:0] en_sh = 14'h0000;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   int wakes = 0;

   assign core_cmd = {bnd, pdone, cmdp, return_from_irq_lvl};

   nic_ctrl #(.PINS_PER_LINE(2), .HALT_CAP(nic_pkg::HALT_CAP_DEF)) uut (.ref_clk(ref_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tli_pin(tli_pin),
      .ext_pin(ext_pin), .periph_flag(periph_flag), .periph_clr(periph_clr),
      .core_cmd(core_cmd), .core_rsp(core_rsp));
   nic_core_model core (.ref_clk(ref_clk), .resetn(resetn), .push(core_rsp.push),
      .delay(dly), .boundary(bnd), .push_done(pdone));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (core_rsp.wake === 1'b1) begin
         wakes <= wakes + 1;
      end
      if (cycles == 6000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      samples_checked++;
      if (got !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask

   task automatic pulse(input int b);
      @(posedge ref_clk);
      cmdp[b] <= 1'b1;
      @(posedge ref_clk);
      cmdp[b] <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic ret(input logic [1:0] l);
      @(posedge ref_clk);
      return_from_irq_lvl <= l;
      cmdp[C_RET] <= 1'b1;
      @(posedge ref_clk);
      cmdp[C_RET] <= 1'b0;
      @(posedge ref_clk);
      chk("level after return", 32'(l), 32'(core_rsp.level));
   endtask

   task automatic take(input logic [15:0] v, input logic [1:0] l, input logic ps);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      do begin
         @(posedge ref_clk);
         n++;
         if (core_rsp.push === 1'b1) seen = 1'b1;
      end while (core_rsp.vec_load !== 1'b1 && n < 80);
      chk("vector", 32'(v), 32'(core_rsp.vec));
      chk("entry level", 32'(l), 32'(core_rsp.level));
      chk("stacked first", 32'(ps), 32'(seen));
   endtask

   task automatic quiet(input int c);
      logic hit;
      hit = 1'b0;
      repeat (c) begin
         @(posedge ref_clk);
         if (core_rsp.push !== 1'b0 || core_rsp.wake !== 1'b0) hit = 1'b1;
      end
      chk("no entry", 32'h0, 32'(hit));
   endtask

   task automatic arm(input int s, input logic [1:0] p);
      prio_sh[s/4][2*(s%4)+:2] = p;
      en_sh[s] = 1'b1;
      apb(1'b1, 8'(4*(s/4)), 32'(prio_sh[s/4]));
      apb(1'b1, nic_pkg::OFS_EN, 32'(en_sh));
      @(posedge ref_clk);
      periph_flag[s] <= 1'b1;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      chk("reset level", 32'(nic_pkg::LVL3), 32'(core_rsp.level));
      resetn <= 1'b1;
      take(nic_pkg::VEC_RESET, nic_pkg::LVL3, 1'b0);
      for (int r = 0; r < 4; r++) rdchk(8'(4*r), 32'hFF);
      rdchk(nic_pkg::OFS_EN, 32'h0);
      rdchk(nic_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      apb(1'b1, nic_pkg::OFS_ISPR0, 32'hCF);
      apb(1'b1, nic_pkg::OFS_ISPR0, 32'h64);
      rdchk(nic_pkg::OFS_ISPR0, 32'h44);
      apb(1'b1, nic_pkg::OFS_ISPR3, 32'h00);
      rdchk(nic_pkg::OFS_ISPR3, 32'hF0);
      apb(1'b1, nic_pkg::OFS_ISPR0 + 8'h04, 32'hFE);
      rdchk(nic_pkg::OFS_ISPR0 + 8'h04, 32'hFF);
      prio_sh[0] = 8'h44;
      prio_sh[3] = 8'hF0;
      pulse(C_DIS);
      rdchk(nic_pkg::OFS_LVL, 32'h28);
      pulse(C_EN);
      chk("level enabled", 32'(nic_pkg::LVL0), 32'(core_rsp.level));
      rdchk(nic_pkg::OFS_LVL, 32'h20);
      for (int i = 0; i < 3; i++) begin
         dly <= 4'(3*i);
         arm(int'(ROWS[i].src), ROWS[i].prio);
         take(ROWS[i].vec, ROWS[i].prio, 1'b1);
         periph_flag[ROWS[i].src] <= 1'b0;
         ret(nic_pkg::LVL0);
      end
      pulse(C_DIS);
      arm(6, 2'b01);
      arm(7, 2'b01);
      arm(8, 2'b00);
      pulse(C_EN);
      take(16'hFFEA, 2'b00, 1'b1);
      quiet(10);
      periph_flag[8] <= 1'b0;
      ret(nic_pkg::LVL0);
      take(16'hFFEE, 2'b01, 1'b1);
      periph_flag[6] <= 1'b0;
      ret(nic_pkg::LVL0);
      take(16'hFFEC, 2'b01, 1'b1);
      periph_flag[7] <= 1'b0;
      ret(nic_pkg::LVL0);
      pulse(C_DIS);
      arm(9, 2'b01);
      @(posedge ref_clk);
      periph_clr[9] <= 1'b1;
      @(posedge ref_clk);
      periph_clr[9] <= 1'b0;
      pulse(C_EN);
      quiet(12);
      periph_flag[9] <= 1'b0;
      pulse(C_DIS);
      pulse(C_TRAP);
      take(nic_pkg::VEC_TRAP, nic_pkg::LVL3, 1'b1);
      en_sh[0] = 1'b1;
      apb(1'b1, nic_pkg::OFS_EN, 32'(en_sh));
      tli_pin <= 1'b1;
      take(nic_pkg::VEC_SRC0, nic_pkg::LVL3, 1'b1);
      tli_pin <= 1'b0;
      // the top-pin routine returns without trapping
      ret(nic_pkg::LVL3);
      ret(nic_pkg::LVL3);
      pulse(C_EN);
      apb(1'b1, nic_pkg::OFS_PINEN, 32'h08);
      arm(3, 2'b01);
      @(posedge ref_clk);
      ext_pin[3] <= 1'b1;
      take(16'hFFF4, 2'b01, 1'b1);
      apb(1'b0, nic_pkg::OFS_STAT, 32'h0);
      chk("ext pending", 32'h0, 32'(rd[3]));
      ext_pin[3] <= 1'b0;
      periph_flag[3] <= 1'b0;
      ret(nic_pkg::LVL0);
      pulse(C_HALT);
      arm(9, 2'b11);
      quiet(10);
      arm(8, 2'b01);
      take(16'hFFEA, 2'b01, 1'b1);
      chk("halt wake", 32'h1, 32'(wakes));
      periph_flag[8] <= 1'b0;
      ret(nic_pkg::LVL0);
      take(16'hFFE8, 2'b11, 1'b1);
      periph_flag[9] <= 1'b0;
      ret(nic_pkg::LVL0);
      pulse(C_WAIT);
      arm(10, 2'b01);
      take(16'hFFE6, 2'b01, 1'b1);
      chk("wait wake", 32'h2, 32'(wakes));
      periph_flag[10] <= 1'b0;
      ret(nic_pkg::LVL0);
      apb(1'b1, nic_pkg::OFS_CTRL, 32'h0);
      tli_pin <= 1'b1;
      quiet(8);
      tli_pin <= 1'b0;
      take(nic_pkg::VEC_SRC0, nic_pkg::LVL3, 1'b1);
      ret(nic_pkg::LVL0);
      // only reset can end this halt: no capable source is pending
      pulse(C_HALT);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("reset level again", 32'(nic_pkg::LVL3), 32'(core_rsp.level));
      resetn <= 1'b1;
      take(nic_pkg::VEC_RESET, nic_pkg::LVL3, 1'b0);
      apb(1'b0, nic_pkg::OFS_STAT, 32'h0);
      chk("halt after reset", 32'h0, 32'(rd[16]));
      report_and_stop();
   end
endmodule
